//--- lmx_map.vh
// Register map and field layout for the block transfer address registers.
`ifndef LMX_MAP_VH
`define LMX_MAP_VH
`define LMX_OFS_SRC0       8'h50
`define LMX_OFS_SRC1       8'h54
`define LMX_OFS_DST0       8'h58
`define LMX_OFS_DST1       8'h5c
`define LMX_OFS_MODE       8'h60
`define LMX_BASE_HI        28
`define LMX_BASE_LO        10
`define LMX_MASK_HI        5
`define LMX_MASK_LO        0
`define LMX_WMASK          32'h1ffffc3f
`define LMX_MODE_WMASK     32'h00000003
`define LMX_FIELD_INIT     32'h00000000
`define LMX_RESP_OKAY      2'b00
`define LMX_RESP_SLVERR    2'b10
`endif

//--- lmx_xfer_addr.v
// Block transfer external address registers with AXI4-Lite access.
`timescale 1ns/1ps
`default_nettype none
`include "lmx_map.vh"
// Overview of operation
// [R1] Page1 prefetch source from page1 source register
// [R2] Reserved bits 31:29, 9:6 read zero
// [R3] Page1 source base field bits 28:10
// [R4] Page1 source mask picks base or operand
// [R5] Software uses contiguous mask ladder values only
// [R6] Software never writes other mask patterns
// [R7] Page0 write-back destination from page0 destination
// [R8] Page0 destination base field bits 28:10
// [R9] Page0 destination mask picks base or operand
// [R10] Page1 write-back destination from page1 destination
// [R11] Page1 destination base field bits 28:10
// [R12] Page1 destination mask picks base or operand
// [R13] Destination masks follow same ladder
// [R14] Page0 source mask steers like page1
// [R15] Bits 9:5 from operand, 4:0 zero
// [R16] Transfers move 32 aligned bytes
// [R17] Fields reset arbitrary; reserved bits zero
module lmx_xfer_addr (
	input  wire        core_clk,
	input  wire        rst_n,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        xfer_req,
	input  wire        xfer_write_back,
	input  wire        xfer_page,
	input  wire [31:0] xfer_operand_addr,
	output reg         xfer_addr_valid,
	output reg  [28:0] xfer_phys_addr,
	output reg         xfer_uses_regs
);

	// ****************************************
	// Reset synchroniser
	// ****************************************
	// Entry into reset stays asynchronous; only the release is timed to
	// the clock, so the handshake flops and xfer_addr_valid leave reset on the same edge;
	// the register fields, mode_q and the data flops follow rst_n directly.
	reg rst_meta_q;
	reg rst_sync_q;
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end
	wire rst_int_n = rst_sync_q;

	// ****************************************
	// Register storage
	// ****************************************
	// Index 0 src page0, 1 src page1, 2 dst page0, 3 dst page1.
	reg  [31:0] regs_q [0:3];
	// Bit 0 translation enable, bit 1 memory protection enable.
	reg  [1:0]  mode_q;

	reg         aw_held_q;
	reg  [7:0]  aw_addr_q;
	reg         w_held_q;
	reg  [31:0] w_data_q;
	reg  [3:0]  w_strb_q;

	wire [31:0] strb_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
	                         {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
	wire        do_write  = aw_held_q && w_held_q && !s_axi_bvalid;
	// Full offsets are decoded, so an unaligned or unmapped address hits
	// no register and earns an error response.
	wire [3:0]  wr_hit    = {aw_addr_q == `LMX_OFS_DST1,
	                         aw_addr_q == `LMX_OFS_DST0,
	                         aw_addr_q == `LMX_OFS_SRC1,
	                         aw_addr_q == `LMX_OFS_SRC0};
	wire        wr_reg    = |wr_hit;
	wire        wr_mode   = aw_addr_q == `LMX_OFS_MODE;
	wire [31:0] mode_wdata = w_data_q & `LMX_MODE_WMASK;

	// ****************************************
	// Write channel
	// ****************************************
	// Fields come up zero rather than unknown, so that a read before the
	// first write gives the same answer on every run.
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_reg
			always @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					regs_q[gi] <= `LMX_FIELD_INIT; // R17
				end else if (do_write && wr_hit[gi]) begin
					// Reserved bits are never stored. R2
					regs_q[gi] <= (regs_q[gi] & ~(strb_mask & `LMX_WMASK))
					            | (w_data_q & strb_mask & `LMX_WMASK); // R3 R8 R11
				end
			end
		end
	endgenerate

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held_q     <= 1'b0;
			aw_addr_q     <= 8'h00;
			w_held_q      <= 1'b0;
			w_data_q      <= 32'h00000000;
			w_strb_q      <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `LMX_RESP_OKAY;
			mode_q        <= 2'b00;
		end else if (!rst_int_n) begin
			aw_held_q     <= 1'b0;
			w_held_q      <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held_q && !s_axi_awready;
			s_axi_wready  <= !w_held_q && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q     <= 1'b1;
				aw_addr_q     <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q     <= 1'b1;
				w_data_q     <= s_axi_wdata;
				w_strb_q     <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_held_q    <= 1'b0;
				w_held_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_reg || wr_mode)
				                ? `LMX_RESP_OKAY : `LMX_RESP_SLVERR;
				if (wr_mode && w_strb_q[0])
					mode_q <= mode_wdata[1:0];
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ****************************************
	// Read channel
	// ****************************************
	wire [7:0]  ra      = s_axi_araddr;
	wire [3:0]  rd_hit  = {ra == `LMX_OFS_DST1, ra == `LMX_OFS_DST0,
	                       ra == `LMX_OFS_SRC1, ra == `LMX_OFS_SRC0};
	wire        rd_reg  = |rd_hit;
	wire        rd_mode = ra == `LMX_OFS_MODE;
	reg  [31:0] rd_word;

	// The mux is one-hot on the decoded offset, so an unmapped address
	// falls through to zero rather than aliasing onto a register.
	always @* begin
		case (rd_hit)
			4'b0001: rd_word = regs_q[0];
			4'b0010: rd_word = regs_q[1];
			4'b0100: rd_word = regs_q[2];
			4'b1000: rd_word = regs_q[3];
			default: rd_word = 32'h00000000;
		endcase
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `LMX_RESP_OKAY;
		end else if (!rst_int_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				if (rd_reg) begin
					s_axi_rdata <= rd_word & `LMX_WMASK; // R2
					s_axi_rresp <= `LMX_RESP_OKAY;
				end else if (rd_mode) begin
					s_axi_rdata <= {30'h00000000, mode_q};
					s_axi_rresp <= `LMX_RESP_OKAY;
				end else begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `LMX_RESP_SLVERR;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ****************************************
	// Register fields
	// ****************************************
	// Reserved bits are never stored, so only the fields are named here.
	wire [18:0] page0_source_base =
	            regs_q[0][`LMX_BASE_HI:`LMX_BASE_LO];
	wire [5:0]  page0_source_select_mask =
	            regs_q[0][`LMX_MASK_HI:`LMX_MASK_LO]; // R14
	wire [18:0] page1_source_base =
	            regs_q[1][`LMX_BASE_HI:`LMX_BASE_LO]; // R3
	wire [5:0]  page1_source_select_mask =
	            regs_q[1][`LMX_MASK_HI:`LMX_MASK_LO]; // R4
	wire [18:0] page0_destination_base =
	            regs_q[2][`LMX_BASE_HI:`LMX_BASE_LO]; // R8
	wire [5:0]  page0_destination_select_mask =
	            regs_q[2][`LMX_MASK_HI:`LMX_MASK_LO]; // R9
	wire [18:0] page1_destination_base =
	            regs_q[3][`LMX_BASE_HI:`LMX_BASE_LO]; // R11
	wire [5:0]  page1_destination_select_mask =
	            regs_q[3][`LMX_MASK_HI:`LMX_MASK_LO]; // R12

	// ****************************************
	// External address formation
	// ****************************************
	// Prefetch uses the source register of its page, write-back the
	// destination register. The mask is applied as written; a
	// non-ladder mask gives a scattered but well-defined address.
	// Both enables must be set before the translation path takes over;
	// either one alone leaves these registers in charge.
	wire        address_translation_enable      = mode_q[0];
	wire        onchip_memory_protection_enable = mode_q[1];
	wire        use_regs = !(address_translation_enable
	                         && onchip_memory_protection_enable); // R1 R7 R10
	wire [1:0]  sel_idx  = {xfer_write_back, xfer_page}; // R1 R7 R10 R14
	reg  [18:0] sel_base;
	reg  [5:0]  sel_mask;
	wire [5:0]  mid_bits;

	always @* begin
		case (sel_idx)
			2'b00: begin
				sel_base = page0_source_base;
				sel_mask = page0_source_select_mask; // R14
			end
			2'b01: begin
				sel_base = page1_source_base; // R1
				sel_mask = page1_source_select_mask; // R4
			end
			2'b10: begin
				sel_base = page0_destination_base; // R7
				sel_mask = page0_destination_select_mask; // R9
			end
			2'b11: begin
				sel_base = page1_destination_base; // R10
				sel_mask = page1_destination_select_mask; // R12
			end
			default: begin
				sel_base = 19'h00000;
				sel_mask = 6'h00;
			end
		endcase
	end

	// One mux per address bit 15:10; a one in the mask keeps the base bit.
	genvar mb;
	generate
		for (mb = 0; mb < 6; mb = mb + 1) begin : g_mid
			assign mid_bits[mb] = sel_mask[mb] ? sel_base[mb]
			                    : xfer_operand_addr[10 + mb]; // R4 R9 R12 R14
		end
	endgenerate

	// When translation and protection are both on, the address comes
	// from the translation path outside; this block only flags that.
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			xfer_addr_valid <= 1'b0;
			xfer_phys_addr  <= 29'h00000000;
			xfer_uses_regs  <= 1'b0;
		end else if (!rst_int_n) begin
			xfer_addr_valid <= 1'b0;
		end else begin
			xfer_addr_valid <= xfer_req;
			xfer_uses_regs  <= use_regs;
			if (xfer_req)
				xfer_phys_addr <= {sel_base[18:6], mid_bits,
				                   xfer_operand_addr[9:5], 5'h00}; // R15 R16
		end
	end

endmodule // lmx_xfer_addr
`default_nettype wire

//--- lmx_xfer_addr_chk.sv
// Checker of the block transfer address register bank.
`timescale 1ns/1ps
`default_nettype none
module lmx_xfer_addr_chk (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        xfer_req,
	input wire logic [31:0] xfer_operand_addr,
	input wire logic        xfer_addr_valid,
	input wire logic [28:0] xfer_phys_addr
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	AST_VALID: assert property (xfer_req |=> xfer_addr_valid)
		else $error("address not answered");
	AST_QUIET: assert property (!xfer_req |=> !xfer_addr_valid)
		else $error("answer without request");
	AST_ZERO: assert property (xfer_addr_valid |-> xfer_phys_addr[4:0] == 5'h0)
		else $error("low address bits not zero");
	AST_MID: assert property (xfer_req |=>
		xfer_phys_addr[9:5] == $past(xfer_operand_addr[9:5]))
		else $error("bits 9:5 not from operand");
	AST_HOLD: assert property (!xfer_req |=> $stable(xfer_phys_addr))
		else $error("address moved without request");
	AST_RSV: assert property (s_axi_rvalid |->
		s_axi_rdata[31:29] == 3'h0 && s_axi_rdata[9:6] == 4'h0)
		else $error("reserved bits read nonzero");
	AST_BONCE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	AST_RONCE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read response repeated");
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && s_axi_rready);
	cover property (xfer_addr_valid);
endmodule // lmx_xfer_addr_chk
bind lmx_xfer_addr lmx_xfer_addr_chk chk_u (
	.core_clk          (core_clk),
	.rst_n             (rst_n),
	.s_axi_bvalid      (s_axi_bvalid),
	.s_axi_bready      (s_axi_bready),
	.s_axi_rvalid      (s_axi_rvalid),
	.s_axi_rready      (s_axi_rready),
	.s_axi_rdata       (s_axi_rdata),
	.xfer_req          (xfer_req),
	.xfer_operand_addr (xfer_operand_addr),
	.xfer_addr_valid   (xfer_addr_valid),
	.xfer_phys_addr    (xfer_phys_addr)
);
`default_nettype wire

//--- lmx_xfer_addr_tb.sv
// Self-checking testbench of the block transfer address register bank.
`timescale 1ns/1ps
`default_nettype none
module lmx_xfer_addr_tb;
	logic core_clk = 1'h0, rst_n = 1'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
	logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic xfer_req = 1'h0, xfer_write_back = 1'h0, xfer_page = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, xfer_addr_valid, xfer_uses_regs;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0, xfer_operand_addr = 32'h0;
	logic [31:0] s_axi_rdata, d, mdl[4];
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [28:0] xfer_phys_addr;
	int failures = 0, comparisons = 0, cyc = 0, i, k;
	lmx_xfer_addr dut_u (
		.core_clk          (core_clk),
		.rst_n             (rst_n),
		.s_axi_awaddr      (s_axi_awaddr),
		.s_axi_awvalid     (s_axi_awvalid),
		.s_axi_awready     (s_axi_awready),
		.s_axi_wdata       (s_axi_wdata),
		.s_axi_wstrb       (s_axi_wstrb),
		.s_axi_wvalid      (s_axi_wvalid),
		.s_axi_wready      (s_axi_wready),
		.s_axi_bresp       (s_axi_bresp),
		.s_axi_bvalid      (s_axi_bvalid),
		.s_axi_bready      (s_axi_bready),
		.s_axi_araddr      (s_axi_araddr),
		.s_axi_arvalid     (s_axi_arvalid),
		.s_axi_arready     (s_axi_arready),
		.s_axi_rdata       (s_axi_rdata),
		.s_axi_rresp       (s_axi_rresp),
		.s_axi_rvalid      (s_axi_rvalid),
		.s_axi_rready      (s_axi_rready),
		.xfer_req          (xfer_req),
		.xfer_write_back   (xfer_write_back),
		.xfer_page         (xfer_page),
		.xfer_operand_addr (xfer_operand_addr),
		.xfer_addr_valid   (xfer_addr_valid),
		.xfer_phys_addr    (xfer_phys_addr),
		.xfer_uses_regs    (xfer_uses_regs)
	);
	always #25 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			finish_test;
		end
	end
	task finish_test;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	// The mask bit chooses base when one, operand when zero.
	function logic [28:0] xa(input logic [31:0] g, input logic [31:0] o);
		return {g[28:16], g[5:0] & g[15:10] | ~g[5:0] & o[15:10], o[9:5], 5'h0};
	endfunction
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task xf(input logic w, input logic p, input logic [31:0] o, input logic u);
		@(posedge core_clk);
		xfer_req <= 1'h1;
		xfer_write_back <= w;
		xfer_page <= p;
		xfer_operand_addr <= o;
		@(posedge core_clk);
		xfer_req <= 1'h0;
		#1;
		chk("valid", 32'h1, xfer_addr_valid);
		chk("uses_regs", u, xfer_uses_regs);
		if (u) chk("addr", xa(mdl[{w, p}], o), xfer_phys_addr);
	endtask
	initial begin
		void'($urandom(71668));
		repeat (2) @(posedge core_clk);
		rst_n <= 1'h1;
		repeat (3) @(posedge core_clk);
		for (i = 0; i < 4; i++) begin
			mdl[i] = 32'h0;
			rd(8'h50 + 8'(4 * i));
			chk("reset", 32'h0, d);
		end
		rd(8'h00);
		chk("unmapped", 32'h2, r);
		wr(8'h61, 32'h0);
		chk("misaligned", 32'h2, r);
		// Registers stay in charge unless both enables are set.
		for (i = 0; i < 4; i++) begin
			wr(8'h60, 32'(i));
			chk("mode bresp", 32'h0, r);
			rd(8'h60);
			chk("mode", 32'(i), d);
			xf(1'h0, 1'h1, $urandom, i != 3);
		end
		wr(8'h60, 32'h0);
		// Only ladder masks are written, as software is obliged to.
		for (i = 0; i < 60; i++) begin
			k = $urandom % 4;
			d = $urandom & 32'h1ffffc00
			    | {26'h0, 6'h3f << ($urandom % 7)};
			wr(8'h50 + 8'(4 * k), d);
			chk("bresp", 32'h0, r);
			mdl[k] = d;
			rd(8'h50 + 8'(4 * k));
			chk("readback", mdl[k], d);
			xf(k[1], k[0], $urandom, 1'h1);
		end
		rst_n <= 1'h0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'h1;
		repeat (3) @(posedge core_clk);
		rd(8'h5c);
		chk("reset again", 32'h0, d);
		chk("uses_regs reset", 32'h1, xfer_uses_regs);
		finish_test;
	end
endmodule // lmx_xfer_addr_tb
`default_nettype wire
